// ===== rtl/bub_defines.svh
// offsets, field positions, reset values and timing counts
`ifndef BUB_DEFINES_SVH
`define BUB_DEFINES_SVH
`define CLK_HZ 40000000
`define RATE1_BPS 12500
`define RATE2_BPS 25000
`define RATE4_BPS 50000
`define TICK1_CYC ((`CLK_HZ + `RATE1_BPS - 1) / `RATE1_BPS)
`define TICK2_CYC ((`CLK_HZ + `RATE2_BPS - 1) / `RATE2_BPS)
`define TICK4_CYC ((`CLK_HZ + `RATE4_BPS - 1) / `RATE4_BPS)
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_COUNT 8'h08
`define OFS_STATUS 8'h0c
`define OFS_DATA 8'h10
`define OFS_ISTAT 8'h14
`define OFS_IMASK 8'h18
`define CTRL_START_BIT 0
`define CTRL_DIR_LSB 1
`define CTRL_MODE_LSB 3
`define CTRL_ELEM_LSB 5
`define ST_FIFO_RDY_BIT 7
`define ST_FIFO_DATA_BIT 8
`define ST_LEVEL_LSB 16
`define INT_DRQ_BIT 0
`define INT_STAT_BIT 1
`define INT_DONE_BIT 2
`define FIFO_DEPTH 6'h20
`define FIFO_HALF 6'h10
`define ADDR_RST 16'h0000
`define COUNT_RST 16'h0000
`define IMASK_RST 3'h0
`endif

// ===== rtl/bub_pkg.sv
// types shared by the transfer logic
package bub_pkg;
  typedef enum logic [1:0] {DIR_MEM2FIFO = 2'h0, DIR_FIFO2MEM = 2'h1, DIR_VERIFY = 2'h2} dir_e;
  typedef enum logic [1:0] {MODE_POLL = 2'h0, MODE_DRQ = 2'h1, MODE_DMA = 2'h2} mode_e;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARB = 5'h02,
    ST_MOVE = 5'h04,
    ST_HOLD = 5'h08,
    ST_END = 5'h10
  } eng_st_e;
endpackage

// ===== rtl/xfer_if.sv
// link between the register side and the dma engine
`timescale 1ns/1ps
interface xfer_if;
  logic start;
  bub_pkg::dir_e dir;
  logic [15:0] addr;
  logic [15:0] count;
  logic busy;
  logic done;
  logic push;
  logic pop;
  logic [7:0] wdata;
  logic full;
  logic empty;
  logic [7:0] rdata;
  modport ctl(output start, dir, addr, count, full, empty, rdata, input busy, done, push, pop, wdata);
  modport eng(input start, dir, addr, count, full, empty, rdata, output busy, done, push, pop, wdata);
endinterface

// ===== rtl/bub_dma_engine.sv
// dma engine moving bytes between system memory and the controller fifo
`timescale 1ns/1ps
`include "bub_defines.svh"
module bub_dma_engine (
  input wire logic i_clk,
  input wire logic i_rst_b,
  xfer_if.eng x,
  output logic o_bus_req,
  input wire logic i_bus_grant,
  output logic o_mem_req,
  output logic o_mem_wr,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata
);
  bub_pkg::eng_st_e st_reg, st_next;
  bub_pkg::dir_e dir_reg;
  logic [15:0] addr_reg;
  logic [15:0] cnt_reg;
  logic [7:0] data_reg;
  logic have_reg;
  logic mreq_reg;
  logic wr_reg;

  // decode of the current step
  wire m2f = dir_reg == bub_pkg::DIR_MEM2FIFO;
  wire moving = st_reg == bub_pkg::ST_MOVE;
  wire holding = st_reg == bub_pkg::ST_HOLD;
  wire ack_w = mreq_reg & i_mem_ack;
  wire last_w = cnt_reg == 16'h0001;
  wire step_w = x.push | (ack_w & wr_reg);
  wire fin_w = step_w & last_w;

  // fifo handshakes and bus outputs
  assign x.push = moving & m2f & have_reg & ~x.full;
  assign x.pop = moving & ~m2f & ~have_reg & ~mreq_reg & ~x.empty;
  assign x.wdata = data_reg;
  assign x.busy = st_reg != bub_pkg::ST_IDLE;
  assign x.done = st_reg == bub_pkg::ST_END;
  assign o_bus_req = x.busy & ~x.done;
  assign o_mem_req = mreq_reg;
  assign o_mem_wr = wr_reg;
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = data_reg;

  // next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      bub_pkg::ST_IDLE: if (x.start) st_next = (x.count == 16'h0000) ? bub_pkg::ST_END : bub_pkg::ST_ARB;
      bub_pkg::ST_ARB: if (i_bus_grant) begin
        st_next = (dir_reg == bub_pkg::DIR_VERIFY) ? bub_pkg::ST_HOLD : bub_pkg::ST_MOVE;
      end
      bub_pkg::ST_MOVE: if (fin_w) st_next = bub_pkg::ST_END;
      bub_pkg::ST_HOLD: if (last_w) st_next = bub_pkg::ST_END;
      bub_pkg::ST_END: st_next = bub_pkg::ST_IDLE;
      default: st_next = bub_pkg::ST_IDLE;
    endcase
  end

  // byte path and memory cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= bub_pkg::ST_IDLE;
      dir_reg <= bub_pkg::DIR_MEM2FIFO;
      addr_reg <= `ADDR_RST;
      cnt_reg <= `COUNT_RST;
      data_reg <= 8'h00;
      have_reg <= 1'b0;
      mreq_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (x.start && !x.busy) begin
        dir_reg <= x.dir;
        addr_reg <= x.addr;
        cnt_reg <= x.count;
        have_reg <= 1'b0;
        mreq_reg <= 1'b0;
      end else begin
        if (step_w || holding) cnt_reg <= cnt_reg - 16'h0001;
        if (moving && !have_reg && !mreq_reg && m2f) begin
          mreq_reg <= 1'b1;
          wr_reg <= 1'b0;
        end
        if (moving && have_reg && !mreq_reg && !m2f) begin
          mreq_reg <= 1'b1;
          wr_reg <= 1'b1;
        end
        if (ack_w) begin
          mreq_reg <= 1'b0;
          addr_reg <= addr_reg + 16'h0001;
          have_reg <= ~wr_reg;
          if (!wr_reg) data_reg <= i_mem_rdata;
        end
        if (x.push) have_reg <= 1'b0;
        if (x.pop) begin
          data_reg <= x.rdata;
          have_reg <= 1'b1;
        end
      end
    end
  end

  hold_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    holding |-> o_bus_req && !o_mem_req && !x.push && !x.pop) else $error("verify cycle moved data");
  fetch_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ack_w && !wr_reg) |=> have_reg && x.wdata == $past(i_mem_rdata)) else $error("fetched byte lost");
  pop_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    x.pop |-> ##2 o_mem_req && o_mem_wr && o_mem_wdata == $past(x.rdata, 2)) else $error("popped byte not stored");
  req_steady_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wr))
    else $error("memory request dropped early");
endmodule

// ===== rtl/bubble_board_host_transfer.sv
// host transfer, status and interrupt logic of the bubble memory board
// Notes on behaviour
// - a dma read cycle fetches bytes from system memory and pushes them into the controller fifo.
// - a dma write cycle pops bytes from the controller fifo and stores them into system memory.
// - a dma verify cycle takes and holds the system bus while moving no data.
// - the status register tells polling software whether the fifo can take data or holds data.
// - in data request mode the request pin and an interrupt go active at fifo half empty or half full.
// - in status interrupt mode any change of status bits 6 to 0 raises an interrupt; fifo flag and level changes do not.
// - the status register shows busy, complete, failed, timing, correctable, uncorrectable and parity.
// - the bubble side moves bytes at 12.5K, 25K or 50K bytes per second for one, two or four elements.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bub_defines.svh"
module bubble_board_host_transfer (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_IRQ,
  output logic O_DATA_REQUEST_PIN,
  output logic O_BUS_REQ,
  input wire logic I_BUS_GRANT,
  output logic O_MEM_REQ,
  output logic O_MEM_WR,
  output logic [15:0] O_MEM_ADDR,
  output logic [7:0] O_MEM_WDATA,
  input wire logic I_MEM_ACK,
  input wire logic [7:0] I_MEM_RDATA,
  output logic O_BUB_STB,
  output logic [7:0] O_BUB_DATA,
  input wire logic [7:0] I_BUB_DATA,
  input wire logic I_ERR_CORR,
  input wire logic I_ERR_UNCORR,
  input wire logic I_ERR_PARITY
);
  xfer_if x ();

  bub_pkg::mode_e mode_reg;
  bub_pkg::dir_e dir_reg;
  logic [1:0] elem_reg;
  logic [15:0] addr_reg;
  logic [15:0] count_reg;
  logic [2:0] int_stat_reg;
  logic [2:0] int_stat_next;
  logic [2:0] int_mask_reg;
  logic [2:0] err_s1_reg;
  logic [2:0] err_s2_reg;
  logic op_busy_reg;
  logic done_reg;
  logic fail_reg;
  logic timing_reg;
  logic corr_reg;
  logic uncorr_reg;
  logic parity_reg;
  logic [6:0] stat_prev_reg;
  logic drq_prev_reg;
  logic [7:0] fifo_mem [0:`FIFO_DEPTH-1];
  logic [4:0] wr_ptr_reg;
  logic [4:0] rd_ptr_reg;
  logic [5:0] level_reg;
  logic [11:0] div_cnt_reg;
  logic [15:0] bub_left_reg;
  logic bub_stb_reg;
  logic [7:0] bub_data_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rd_ok_reg;
  logic [31:0] prdata_reg;
  logic [11:0] gap_reg;
  logic tick_seen_reg;

  // apb decode
  wire acc_w = I_PSEL & I_PENABLE;
  wire fin_apb = acc_w & pready_reg;
  wire wr_w = fin_apb & I_PWRITE;
  wire rd_w = fin_apb & ~I_PWRITE;
  wire sel_ctrl = I_PADDR == `OFS_CTRL;
  wire sel_addr = I_PADDR == `OFS_ADDR;
  wire sel_count = I_PADDR == `OFS_COUNT;
  wire sel_status = I_PADDR == `OFS_STATUS;
  wire sel_data = I_PADDR == `OFS_DATA;
  wire sel_istat = I_PADDR == `OFS_ISTAT;
  wire sel_imask = I_PADDR == `OFS_IMASK;
  wire hit_w = sel_ctrl | sel_addr | sel_count | sel_status | sel_data | sel_istat | sel_imask;
  wire [1:0] wmode_w = I_PWDATA[`CTRL_MODE_LSB +: 2];
  wire start_w = wr_w & sel_ctrl & I_PWDATA[`CTRL_START_BIT] & ~op_busy_reg;

  // mode and fifo state
  wire is_dma = mode_reg == bub_pkg::MODE_DMA;
  wire m2f = dir_reg == bub_pkg::DIR_MEM2FIFO;
  wire f2m = dir_reg == bub_pkg::DIR_FIFO2MEM;
  wire full_w = level_reg == `FIFO_DEPTH;
  wire empty_w = level_reg == 6'h00;
  wire [7:0] head_w = fifo_mem[rd_ptr_reg];

  // bubble side byte clock, one enable pulse per byte
  wire [11:0] tick_cyc_w = (elem_reg == 2'h0) ? 12'(`TICK1_CYC) :
                           (elem_reg == 2'h1) ? 12'(`TICK2_CYC) : 12'(`TICK4_CYC);
  wire bub_run = op_busy_reg & (bub_left_reg != 16'h0000);
  wire tick_w = bub_run & (div_cnt_reg == tick_cyc_w - 12'h001);
  wire bub_pop = tick_w & m2f & ~empty_w;
  wire bub_push = tick_w & f2m & ~full_w;
  wire tim_err_w = tick_w & ((m2f & empty_w) | (f2m & full_w));

  // fifo port selection
  wire apb_push = wr_w & sel_data & ~is_dma & m2f & ~full_w;
  wire apb_pop = rd_w & sel_data & ~is_dma & f2m & rd_ok_reg;
  wire push_w = x.push | apb_push | bub_push;
  wire pop_w = x.pop | apb_pop | bub_pop;
  wire [7:0] din_w = f2m ? I_BUB_DATA : (is_dma ? x.wdata : I_PWDATA[7:0]);
  wire finish_w = op_busy_reg & (bub_left_reg == 16'h0000) & ~x.busy;

  // status word and events
  wire [6:0] status7_w = {parity_reg, uncorr_reg, corr_reg, timing_reg, fail_reg, done_reg, op_busy_reg};
  wire [31:0] status_w = {10'h000, level_reg, 7'h00, ~empty_w, ~full_w, status7_w};
  wire stat_chg_w = status7_w != stat_prev_reg;
  wire drq_w = op_busy_reg & (mode_reg == bub_pkg::MODE_DRQ) &
               ((m2f & (level_reg <= `FIFO_HALF)) | (f2m & (level_reg >= `FIFO_HALF)));
  wire [2:0] ev_w = {finish_w, stat_chg_w, drq_w & ~drq_prev_reg};
  wire [2:0] clr_w = ({3{wr_w & sel_istat}} & I_PWDATA[2:0]) |
                     ({3{rd_w & sel_status}} & 3'h2);

  // read data selection
  wire [31:0] ctrl_rd_w = {25'h0000000, elem_reg, mode_reg, dir_reg, 1'b0};
  wire [31:0] rd_mux_w = sel_ctrl ? ctrl_rd_w :
                         sel_addr ? {16'h0000, addr_reg} :
                         sel_count ? {16'h0000, count_reg} :
                         sel_status ? status_w :
                         sel_data ? {24'h000000, empty_w ? 8'h00 : head_w} :
                         sel_istat ? {29'h00000000, int_stat_reg} :
                         sel_imask ? {29'h00000000, int_mask_reg} : 32'h00000000;

  // engine hookup and outputs
  assign x.start = start_w & (wmode_w == bub_pkg::MODE_DMA);
  assign x.dir = bub_pkg::dir_e'(I_PWDATA[`CTRL_DIR_LSB +: 2]);
  assign x.addr = addr_reg;
  assign x.count = count_reg;
  assign x.full = full_w;
  assign x.empty = empty_w;
  assign x.rdata = head_w;
  assign int_stat_next = (int_stat_reg & ~clr_w) | ev_w;
  assign O_IRQ = |(int_stat_reg & int_mask_reg);
  assign O_DATA_REQUEST_PIN = drq_w;
  assign O_PRDATA = prdata_reg;
  assign O_PREADY = pready_reg;
  assign O_PSLVERR = pslverr_reg;
  assign O_BUB_STB = bub_stb_reg;
  assign O_BUB_DATA = bub_data_reg;

  bub_dma_engine u_eng (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .x(x),
    .o_bus_req(O_BUS_REQ),
    .i_bus_grant(I_BUS_GRANT),
    .o_mem_req(O_MEM_REQ),
    .o_mem_wr(O_MEM_WR),
    .o_mem_addr(O_MEM_ADDR),
    .o_mem_wdata(O_MEM_WDATA),
    .i_mem_ack(I_MEM_ACK),
    .i_mem_rdata(I_MEM_RDATA)
  );

  // error pins into the clock domain
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      err_s1_reg <= 3'h0;
      err_s2_reg <= 3'h0;
    end else begin
      err_s1_reg <= {I_ERR_PARITY, I_ERR_UNCORR, I_ERR_CORR};
      err_s2_reg <= err_s1_reg;
    end
  end

  // software written configuration
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_reg <= bub_pkg::MODE_POLL;
      dir_reg <= bub_pkg::DIR_MEM2FIFO;
      elem_reg <= 2'h0;
      addr_reg <= `ADDR_RST;
      count_reg <= `COUNT_RST;
      int_mask_reg <= `IMASK_RST;
    end else if (wr_w) begin
      if (sel_ctrl && !op_busy_reg) begin
        mode_reg <= bub_pkg::mode_e'(wmode_w);
        dir_reg <= bub_pkg::dir_e'(I_PWDATA[`CTRL_DIR_LSB +: 2]);
        elem_reg <= I_PWDATA[`CTRL_ELEM_LSB +: 2];
      end
      if (sel_addr) addr_reg <= I_PWDATA[15:0];
      if (sel_count) count_reg <= I_PWDATA[15:0];
      if (sel_imask) int_mask_reg <= I_PWDATA[2:0];
    end
  end

  // interrupt status, set wins over clear
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      int_stat_reg <= 3'h0;
      stat_prev_reg <= 7'h00;
      drq_prev_reg <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      stat_prev_reg <= status7_w;
      drq_prev_reg <= drq_w;
    end
  end

  // operation status flags
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      op_busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      timing_reg <= 1'b0;
      corr_reg <= 1'b0;
      uncorr_reg <= 1'b0;
      parity_reg <= 1'b0;
    end else if (start_w) begin
      op_busy_reg <= 1'b1;
      {done_reg, fail_reg, timing_reg, corr_reg, uncorr_reg, parity_reg} <= 6'h00;
    end else if (op_busy_reg) begin
      if (tim_err_w) timing_reg <= 1'b1;
      if (err_s2_reg[0]) corr_reg <= 1'b1;
      if (err_s2_reg[1]) uncorr_reg <= 1'b1;
      if (err_s2_reg[2]) parity_reg <= 1'b1;
      if (finish_w) begin
        op_busy_reg <= 1'b0;
        done_reg <= 1'b1;
        fail_reg <= timing_reg | uncorr_reg | err_s2_reg[1];
      end
    end
  end

  // fifo storage
  always_ff @(posedge I_REF_CLK) begin
    if (push_w) fifo_mem[wr_ptr_reg] <= din_w;
  end

  // fifo pointers and level
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wr_ptr_reg <= 5'h00;
      rd_ptr_reg <= 5'h00;
      level_reg <= 6'h00;
    end else if (start_w) begin
      wr_ptr_reg <= 5'h00;
      rd_ptr_reg <= 5'h00;
      level_reg <= 6'h00;
    end else begin
      if (push_w) wr_ptr_reg <= wr_ptr_reg + 5'h01;
      if (pop_w) rd_ptr_reg <= rd_ptr_reg + 5'h01;
      level_reg <= level_reg + {5'h00, push_w} - {5'h00, pop_w};
    end
  end

  // bubble side pacing and byte output
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      div_cnt_reg <= 12'h000;
      bub_left_reg <= 16'h0000;
      bub_stb_reg <= 1'b0;
      bub_data_reg <= 8'h00;
    end else if (start_w) begin
      div_cnt_reg <= 12'h000;
      bub_left_reg <= count_reg;
      bub_stb_reg <= 1'b0;
    end else begin
      bub_stb_reg <= bub_pop;
      if (bub_pop) bub_data_reg <= head_w;
      if (bub_run) div_cnt_reg <= tick_w ? 12'h000 : div_cnt_reg + 12'h001;
      if (tick_w) bub_left_reg <= bub_left_reg - 16'h0001;
    end
  end

  // apb slave, one wait state per access
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      rd_ok_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= acc_w & ~pready_reg;
      if (acc_w && !pready_reg) begin
        prdata_reg <= I_PWRITE ? 32'h00000000 : rd_mux_w;
        pslverr_reg <= ~hit_w;
        rd_ok_reg <= ~empty_w;
      end
    end
  end

  // byte spacing watch for the rate check
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      gap_reg <= 12'h000;
      tick_seen_reg <= 1'b0;
    end else if (start_w) begin
      gap_reg <= 12'h000;
      tick_seen_reg <= 1'b0;
    end else if (bub_run) begin
      gap_reg <= tick_w ? 12'h000 : gap_reg + 12'h001;
      if (tick_w) tick_seen_reg <= 1'b1;
    end
  end

  byte_rate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    tick_w && tick_seen_reg |-> gap_reg == tick_cyc_w - 12'h001) else $error("bubble byte rate wrong");
  drq_irq_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    $rose(O_DATA_REQUEST_PIN) |=> int_stat_reg[`INT_DRQ_BIT]) else $error("data request without interrupt");
  drq_drop_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (m2f && level_reg > `FIFO_HALF) || (f2m && level_reg < `FIFO_HALF) |-> !O_DATA_REQUEST_PIN)
    else $error("data request held past threshold");
  stat_chg_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    status7_w != $past(status7_w) |=> int_stat_reg[`INT_STAT_BIT]) else $error("status change not flagged");
  stat_clr_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    rd_w && sel_status && !stat_chg_w |=> !int_stat_reg[`INT_STAT_BIT]) else $error("status read kept pending");
  status_rd_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    acc_w && !pready_reg && !I_PWRITE && sel_status |=> O_PREADY && O_PRDATA[0] == $past(op_busy_reg) &&
    O_PRDATA[`ST_FIFO_RDY_BIT] == $past(!full_w) && O_PRDATA[`ST_FIFO_DATA_BIT] == $past(!empty_w))
    else $error("status word wrong");
endmodule

// ===== tb/sysmem_model.sv
// system bus partner: arbiter and byte-wide memory
`timescale 1ns/1ps
module sysmem_model (
  input wire logic i_clk,
  input wire logic i_bus_req,
  output logic o_bus_grant,
  input wire logic i_mem_req,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_mem_ack,
  output logic [7:0] o_mem_rdata
);
  logic [7:0] mem [0:255];
  integer mseed = 32'h572e;
  // memory preload, a known pattern per address
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    o_bus_grant = 1'b0;
    o_mem_ack = 1'b0;
    o_mem_rdata = 8'h00;
  end
  // grant and acknowledge after random delays; stale read data toggles
  always @(posedge i_clk) begin
    o_mem_ack <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata;
    if (!i_bus_req) begin
      o_bus_grant <= 1'b0;
    end else if (($random(mseed) & 3) == 0) begin
      o_bus_grant <= 1'b1;
    end
    if (i_mem_req && o_bus_grant && !o_mem_ack && ($random(mseed) & 1)) begin
      o_mem_ack <= 1'b1;
      if (i_mem_wr) begin
        mem[i_mem_addr[7:0]] <= i_mem_wdata;
      end else begin
        o_mem_rdata <= mem[i_mem_addr[7:0]];
      end
    end
  end
endmodule

// ===== tb/bubble_board_host_transfer_bench.sv
// self-checking bench of the host transfer block
`timescale 1ns/1ps
`include "bub_defines.svh"
module bubble_board_host_transfer_bench;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_corr = 1'b0;
  logic err_uncorr = 1'b0, err_parity = 1'b0;
  logic [7:0] paddr = 8'h00, bub_in = 8'h00, mem_wdata, mem_rdata, bub_data;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, data_request_pin, bus_req, grant, mem_req, mem_wr, ack, bub_stb, e;
  logic [15:0] mem_addr, a;
  logic [7:0] stb_q [$];
  integer failures = 0, n_compared = 0, seed = 32'h572e;
  integer cyc = 0, mreq_cyc = 0, breq_cyc = 0, last_stb = 0, gap = 0, m0, b0;

  always #12.5 clk = ~clk;

  bubble_board_host_transfer bubble_board_host_transfer_inst (.I_REF_CLK(clk), .I_RST_B(rst_b),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq), .O_DATA_REQUEST_PIN(data_request_pin),
    .O_BUS_REQ(bus_req), .I_BUS_GRANT(grant), .O_MEM_REQ(mem_req), .O_MEM_WR(mem_wr),
    .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .I_MEM_ACK(ack), .I_MEM_RDATA(mem_rdata),
    .O_BUB_STB(bub_stb), .O_BUB_DATA(bub_data), .I_BUB_DATA(bub_in), .I_ERR_CORR(err_corr),
    .I_ERR_UNCORR(err_uncorr), .I_ERR_PARITY(err_parity));

  sysmem_model sysmem_model_inst (.i_clk(clk), .i_bus_req(bus_req), .o_bus_grant(grant),
    .i_mem_req(mem_req), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
    .o_mem_ack(ack), .o_mem_rdata(mem_rdata));

  // activity counters and storage-side byte capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_req) mreq_cyc <= mreq_cyc + 1;
    if (bus_req) breq_cyc <= breq_cyc + 1;
    if (bub_stb) begin
      stb_q.push_back(bub_data);
      gap <= cyc - last_stb;
      last_stb <= cyc;
    end
  end

  // expected status word from flags and fifo level
  function automatic logic [31:0] st_exp(input logic [2:0] flags, input logic [5:0] lvl);
    return {10'h0, lvl, 7'h0, lvl != 6'h0, lvl != `FIFO_DEPTH, 3'h0, flags, 1'b0};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic start(input logic [1:0] dir, input logic [1:0] mode, input logic [1:0] elem,
                       input logic [15:0] ad, input logic [15:0] n);
    apb(1'b1, `OFS_ADDR, {16'h0, ad});
    apb(1'b1, `OFS_COUNT, {16'h0, n});
    apb(1'b1, `OFS_CTRL, {25'h0, elem, mode, dir, 1'b1});
  endtask

  // poll status until the sequencer is no longer busy
  task automatic wait_idle;
    r = 32'h1;
    for (int i = 0; i < 5000 && r[0] !== 1'b0; i++) apb(1'b0, `OFS_STATUS, 32'h0);
  endtask

  task automatic final_report;
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status reset", r, st_exp(3'h0, 6'h0));
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped err", {r[31:1], e}, 32'h1);
    // polled fill past full: level and can-accept flag
    for (int i = 0; i < 33; i++) apb(1'b1, `OFS_DATA, $random(seed) & 32'hff);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status full", r, st_exp(3'h0, `FIFO_DEPTH));
    // start clears fifo, then underrun gives timing error
    start(2'h0, 2'h0, 2'h2, 16'h0, 16'h1);
    wait_idle;
    check("status timing", r, st_exp(3'h7, 6'h0));
    // dma read: memory to fifo to storage, four-element rate
    stb_q = {};
    a = 16'($random(seed));
    start(2'h0, 2'h2, 2'h2, a, 16'h4);
    wait_idle;
    check("read count", stb_q.size(), 32'h4);
    for (int i = 0; i < 4; i++) check("read byte", stb_q[i], (a[7:0] + i[7:0]) ^ 8'h5a);
    check("byte period", gap, 800);
    check("status read", r, st_exp(3'h1, 6'h0));
    apb(1'b0, `OFS_ISTAT, 32'h0);
    check("finish int", r[2], 1'b1);
    apb(1'b1, `OFS_IMASK, 32'h4);
    repeat (2) @(posedge clk);
    check("irq masked in", irq, 1'b1);
    apb(1'b1, `OFS_ISTAT, 32'h4);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    // dma write: storage bytes land in memory
    bub_in <= 8'($random(seed));
    a = 16'($random(seed));
    start(2'h1, 2'h2, 2'h1, a, 16'h3);
    wait_idle;
    for (int i = 0; i < 3; i++) check("write byte", sysmem_model_inst.mem[a[7:0] + i[7:0]], bub_in);
    // verify: bus held, no memory cycles
    m0 = mreq_cyc;
    b0 = breq_cyc;
    start(2'h2, 2'h2, 2'h2, a, 16'h3);
    wait_idle;
    check("verify mem cycles", mreq_cyc - m0, 0);
    check("verify bus held", breq_cyc > b0, 1);
    // status change interrupt pending until status read
    apb(1'b0, `OFS_ISTAT, 32'h0);
    check("change int read", r[1], 1'b0);
    apb(1'b1, `OFS_IMASK, 32'h2);
    // error pins only latch while an operation runs: short verify in poll mode
    start(2'h2, 2'h0, 2'h2, a, 16'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    check("change irq quiet", irq, 1'b0);
    {err_corr, err_uncorr, err_parity} <= 3'h7;
    repeat (6) @(posedge clk);
    check("change irq", irq, 1'b1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("error flags", r[6:4], 3'h7);
    repeat (2) @(posedge clk);
    check("change irq read", irq, 1'b0);
    {err_corr, err_uncorr, err_parity} <= 3'h0;
    wait_idle;
    check("status failed", r, st_exp(3'h3, 6'h0) | 32'h70);
    apb(1'b1, `OFS_ISTAT, 32'h7);
    // data request mode: pin at half level boundary
    start(2'h0, 2'h1, 2'h0, a, 16'h2);
    repeat (2) @(posedge clk);
    check("drq empty", data_request_pin, 1'b1);
    apb(1'b0, `OFS_ISTAT, 32'h0);
    check("drq int", r[0], 1'b1);
    for (int i = 0; i < 17; i++) begin
      apb(1'b1, `OFS_DATA, $random(seed) & 32'hff);
      @(posedge clk);
      check("drq level", data_request_pin, i < 16);
    end
    wait_idle;
    check("status drq", r, st_exp(3'h1, 6'hf));
    check("drq idle", data_request_pin, 1'b0);
    final_report;
  end
endmodule
